// [logic/gfs_pkg.sv]
package gfs_pkg;

  // Offsets from the I/O base, in bytes
  localparam logic [5:0] GFS_OFF_FUNC_SEL = 6'h00;
  localparam logic [5:0] GFS_OFF_DIR_SEL = 6'h04;
  localparam logic [5:0] GFS_OFF_LEVEL = 6'h0C;
  localparam logic [5:0] GFS_OFF_DRV_TYPE = 6'h14;
  localparam logic [5:0] GFS_OFF_FLASH_EN = 6'h18;
  localparam logic [5:0] GFS_OFF_POL_INV = 6'h2C;

  // Reset values
  localparam logic [31:0] GFS_RST_FUNC_FULL = 32'h00E03060;
  localparam logic [31:0] GFS_RST_FUNC_RED = 32'h0CE030E0;
  localparam logic [31:0] GFS_RST_DIR = 32'h0000FFFF;
  localparam logic [31:0] GFS_RST_LEVEL = 32'h00200000;
  localparam logic [31:0] GFS_VAL_DRV_TYPE = 32'h06630000;
  localparam logic [31:0] GFS_RST_FLASH = 32'h00000000;
  localparam logic [31:0] GFS_RST_POL_INV = 32'h00000000;

  // Writable bits; every other bit is hardwired to its reset value
  localparam logic [31:0] GFS_WR_FUNC_FULL = 32'h0F000B83;
  localparam logic [31:0] GFS_WR_FUNC_RED = 32'h03000B03;
  localparam logic [31:0] GFS_WR_DIR = 32'h18000000;
  localparam logic [31:0] GFS_WR_LEVEL = 32'h1FE30000;
  localparam logic [31:0] GFS_WR_FLASH = 32'h1BE30000;
  localparam logic [31:0] GFS_WR_POL_INV = 32'h18000000;

  // Function-select field positions
  localparam int GFS_FS_ALERT = 27;
  localparam int GFS_FS_SUSCLK = 26;
  localparam int GFS_FS_SUSSTAT = 25;
  localparam int GFS_FS_SLPS3 = 24;
  localparam int GFS_FS_SMBALERT = 11;
  localparam int GFS_FS_AUDIO_IN1 = 9;
  localparam int GFS_FS_DMAREQ1 = 8;
  localparam int GFS_FS_PARITY = 7;
  localparam int GFS_FS_PAIR_B = 1;
  localparam int GFS_FS_PAIR_A = 0;

  // Driven pin range of this bank
  localparam int GFS_PIN_LO = 16;
  localparam int GFS_PIN_HI = 28;

endpackage

// [logic/gfs_reg_word.sv]
`timescale 1ns/1ns
module gfs_reg_word #(
  parameter logic [31:0] RST = 32'h00000000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write port
  input wire logic wrEn,
  input wire logic [3:0] byteEn,
  input wire logic [31:0] wrData,
  input wire logic [31:0] wrMask,
  // Stored value
  output logic [31:0] q
);

  // Bits outside wrMask never change; a bit that wrMask never covers keeps the reset value for good
  for (genvar b = 0; b < 4; b++) begin : g_lane
    for (genvar i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          q[8*b+i] <= RST[8*b+i];
        end else if (wrEn && byteEn[b] && wrMask[8*b+i]) begin
          q[8*b+i] <= wrData[8*b+i];
        end
      end
    end
  end

endmodule // gfs_reg_word

// [logic/gfs_gpio_function_direction_select.sv]
`timescale 1ns/1ns
module gfs_gpio_function_direction_select #(
  parameter bit FULL_VARIANT = 1'b1
) (
  // Clock and resume-well reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // I/O space register port, offset from the I/O base
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [3:0] ioByteEn,
  input wire logic [31:0] ioWrData,
  output logic [31:0] ioRdData,
  // Register state toward the other blocks
  output logic [31:0] pinFunctionSelect,
  output logic [31:0] pinDirectionSelect,
  output logic [31:0] outputFlashEnable,
  output logic [31:0] inputPolarityInvert,
  // Alternate functions of the shared pins 28..16
  input wire logic [12:0] altOut,
  input wire logic [12:0] altOe,
  output logic [12:0] altIn,
  // Pins 28..16
  input wire logic [12:0] pinIn,
  output logic [12:0] pinOut,
  output logic [12:0] pinOe
);
  import gfs_pkg::*;

  // The reduced variant hardwires bits 27, 26 and 7 high, so one storage
  // layout serves both variants with only the masks and reset values changed
  localparam logic [31:0] FUNC_RST =
    FULL_VARIANT ? GFS_RST_FUNC_FULL : GFS_RST_FUNC_RED;
  localparam logic [31:0] FUNC_WR =
    FULL_VARIANT ? GFS_WR_FUNC_FULL : GFS_WR_FUNC_RED;

  // Which function-select bit governs a pin of the 28..16 range
  function automatic logic [4:0] selBitOf(input int pin);
    case (pin)
      28, 27: selBitOf = 5'(GFS_FS_ALERT);
      26: selBitOf = 5'(GFS_FS_SUSCLK);
      25: selBitOf = 5'(GFS_FS_SUSSTAT);
      24: selBitOf = 5'(GFS_FS_SLPS3);
      17: selBitOf = 5'(GFS_FS_PAIR_B);
      16: selBitOf = 5'(GFS_FS_PAIR_A);
      default: selBitOf = 5'h1F;
    endcase
  endfunction

  // Word decode used by both the write and the read side; the two low
  // address bits pick a byte inside the word and never a register
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
    hit = (addr[5:2] == off[5:2]);
  endfunction

  // Reads rebuild hardwired bits from constants as well, so an upset
  // storage flop can never show through a fixed bit
  function automatic logic [31:0] pinned(input logic [31:0] q,
    input logic [31:0] mask, input logic [31:0] rst);
    pinned = (q & mask) | (rst & ~mask);
  endfunction

  logic [31:0] levelReg;
  logic [31:0] levelWrMask;
  logic [31:0] levelView;
  logic [12:0] syncA;
  logic [12:0] syncB;
  logic [12:0] syncC;
  logic [12:0] pinState;
  // Per-pin decode, bit K is pin K plus 16
  logic [12:0] useGpio;
  logic [12:0] gpioInput;
  logic [12:0] next_pinOut;
  logic [12:0] next_pinOe;
  logic [12:0] next_altIn;
  logic [31:0] next_rdData;

  logic wrFuncSel;
  logic wrDirSel;
  logic wrLevel;
  logic wrFlash;
  logic wrPolInv;

  // One decode per register word; the holes and the read-only word
  // decode to no write at all, so writes there are dropped
  always_comb begin
    wrFuncSel = ioWrite && hit(ioAddr, GFS_OFF_FUNC_SEL);
    wrDirSel = ioWrite && hit(ioAddr, GFS_OFF_DIR_SEL);
    wrLevel = ioWrite && hit(ioAddr, GFS_OFF_LEVEL);
    wrFlash = ioWrite && hit(ioAddr, GFS_OFF_FLASH_EN);
    wrPolInv = ioWrite && hit(ioAddr, GFS_OFF_POL_INV);
  end

  // Registers are never locked; rst_n is the resume-well reset
  gfs_reg_word #(.RST(FUNC_RST)) uFuncSel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrFuncSel),
    .byteEn(ioByteEn),
    .wrData(ioWrData),
    .wrMask(FUNC_WR),
    .q(pinFunctionSelect)
  );

  // Only bits 28 and 27 are writable; the rest keep their fixed values
  gfs_reg_word #(.RST(GFS_RST_DIR)) uDirSel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrDirSel),
    .byteEn(ioByteEn),
    .wrData(ioWrData),
    .wrMask(GFS_WR_DIR),
    .q(pinDirectionSelect)
  );

  // Level bits of pins set up as inputs ignore writes
  always_comb begin
    levelWrMask = GFS_WR_LEVEL & ~pinDirectionSelect;
  end

  gfs_reg_word #(.RST(GFS_RST_LEVEL)) uLevel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrLevel),
    .byteEn(ioByteEn),
    .wrData(ioWrData),
    .wrMask(levelWrMask),
    .q(levelReg)
  );

  // Blink and invert are storage only here; what they do to the pins
  // is left to the logic that reads these outputs
  gfs_reg_word #(.RST(GFS_RST_FLASH)) uFlash (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrFlash),
    .byteEn(ioByteEn),
    .wrData(ioWrData),
    .wrMask(GFS_WR_FLASH),
    .q(outputFlashEnable)
  );

  gfs_reg_word #(.RST(GFS_RST_POL_INV)) uPolInv (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(wrPolInv),
    .byteEn(ioByteEn),
    .wrData(ioWrData),
    .wrMask(GFS_WR_POL_INV),
    .q(inputPolarityInvert)
  );

  // Pins are asynchronous: three stages, and a change is taken only when
  // stages two and three agree, so a level caught mid-transition by the
  // first stage is never acted on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 13'h0000;
      syncB <= 13'h0000;
      syncC <= 13'h0000;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinState <= 13'h0000;
    end else begin
      for (int i = 0; i < 13; i++) begin
        if (syncB[i] == syncC[i]) begin
          pinState[i] <= syncC[i];
        end
      end
    end
  end

  // Pin routing; pins with no select bit are unmuxed and always GPIO
  // Index K counts from pin 16, the lowest pin this bank drives
  for (genvar p = GFS_PIN_LO; p <= GFS_PIN_HI; p++) begin : g_pin
    localparam int K = p - GFS_PIN_LO;
    localparam logic [4:0] SB = selBitOf(p);
    localparam bit ODRAIN = !GFS_VAL_DRV_TYPE[p];

    always_comb begin
      if (SB == 5'h1F) begin
        useGpio[K] = 1'b1;
      end else begin
        useGpio[K] = pinFunctionSelect[SB];
      end
      gpioInput[K] = useGpio[K] && pinDirectionSelect[p];
    end

    // Open-drain pins in GPIO output use only pull low; a high level lets go of the pad
    always_comb begin
      next_pinOut[K] = 1'b0;
      next_pinOe[K] = 1'b0;
      if (!useGpio[K]) begin
        next_pinOut[K] = altOut[K];
        next_pinOe[K] = altOe[K];
      end else if (gpioInput[K]) begin
        next_pinOut[K] = 1'b0;
        next_pinOe[K] = 1'b0;
      end else if (ODRAIN) begin
        next_pinOut[K] = 1'b0;
        next_pinOe[K] = !levelReg[p];
      end else begin
        next_pinOut[K] = levelReg[p];
        next_pinOe[K] = 1'b1;
      end
    end

    // Registered so the pad sees no decode glitches
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pinOut[K] <= 1'b0;
        pinOe[K] <= 1'b0;
      end else begin
        pinOut[K] <= next_pinOut[K];
        pinOe[K] <= next_pinOe[K];
      end
    end

    // Alternate logic only sees the pin while it owns it; a GPIO-owned
    // pin reads high so an active-low alternate input stays idle
    always_comb begin
      next_altIn[K] = useGpio[K] ? 1'b1 : pinState[K];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        altIn[K] <= 1'b1;
      end else begin
        altIn[K] <= next_altIn[K];
      end
    end
  end

  // Inputs in GPIO use report the pin state instead of the stored level;
  // outputs read back what software last wrote
  always_comb begin
    levelView = levelReg;
    for (int p = GFS_PIN_LO; p <= GFS_PIN_HI; p++) begin
      if (GFS_WR_LEVEL[p] && gpioInput[p - GFS_PIN_LO]) begin
        levelView[p] = pinState[p - GFS_PIN_LO];
      end
    end
  end

  // Holes and unmapped words read zero
  always_comb begin
    next_rdData = 32'h00000000;
    if (hit(ioAddr, GFS_OFF_FUNC_SEL)) begin
      next_rdData = pinned(pinFunctionSelect, FUNC_WR, FUNC_RST);
    end else if (hit(ioAddr, GFS_OFF_DIR_SEL)) begin
      next_rdData = pinned(pinDirectionSelect, GFS_WR_DIR, GFS_RST_DIR);
    end else if (hit(ioAddr, GFS_OFF_LEVEL)) begin
      next_rdData = pinned(levelView, GFS_WR_LEVEL, GFS_RST_LEVEL);
    end else if (hit(ioAddr, GFS_OFF_DRV_TYPE)) begin
      next_rdData = GFS_VAL_DRV_TYPE;
    end else if (hit(ioAddr, GFS_OFF_FLASH_EN)) begin
      next_rdData = pinned(outputFlashEnable, GFS_WR_FLASH, GFS_RST_FLASH);
    end else if (hit(ioAddr, GFS_OFF_POL_INV)) begin
      next_rdData = pinned(inputPolarityInvert, GFS_WR_POL_INV,
        GFS_RST_POL_INV);
    end
  end

  // Read data holds until the next read; a read and a write in one cycle
  // return the old word, since the mux sees the register before the edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ioRdData <= 32'h00000000;
    end else if (ioRead) begin
      ioRdData <= next_rdData;
    end
  end

endmodule // gfs_gpio_function_direction_select

// [sim/gfs_gpio_function_direction_select_assertions.sv]
`timescale 1ns/1ns
module gfs_checker
  import gfs_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [3:0] ioByteEn,
  input wire logic [31:0] ioWrData,
  input wire logic [31:0] ioRdData,
  input wire logic [31:0] pinFunctionSelect,
  input wire logic [31:0] pinDirectionSelect,
  input wire logic [12:0] altOut,
  input wire logic [12:0] altOe,
  input wire logic [12:0] pinOut,
  input wire logic [12:0] pinOe
);
  localparam logic [31:0] FsMask =
    FULL_VARIANT ? GFS_WR_FUNC_FULL : GFS_WR_FUNC_RED;
  localparam logic [31:0] FsRst =
    FULL_VARIANT ? GFS_RST_FUNC_FULL : GFS_RST_FUNC_RED;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence fsWrite;
    ioWrite && ioAddr[5:2] == 4'h0 && ioByteEn == 4'hF;
  endsequence
  sequence dirWrite;
    ioWrite && ioAddr[5:2] == 4'h1 && ioByteEn == 4'hF;
  endsequence
  // Words 30h..3Ch are outside the map and read like the holes
  sequence holeRead;
    ioRead && (ioAddr[5:2] inside {4'h2, 4'h4, 4'h7, 4'h8, 4'h9, 4'hA,
      4'hC, 4'hD, 4'hE, 4'hF});
  endsequence
  AST_FS_FIXED: assert property (
    (pinFunctionSelect & ~FsMask) == (FsRst & ~FsMask))
    else $error("function select hardwired bits changed");
  AST_FS_WRITE: assert property (fsWrite |=> pinFunctionSelect ==
    (($past(ioWrData) & FsMask) | (FsRst & ~FsMask)))
    else $error("function select write wrong");
  AST_DIR_FIXED: assert property (
    (pinDirectionSelect & ~GFS_WR_DIR) == (GFS_RST_DIR & ~GFS_WR_DIR))
    else $error("direction hardwired bits changed");
  AST_DIR_WRITE: assert property (dirWrite |=> pinDirectionSelect ==
    (($past(ioWrData) & GFS_WR_DIR) | (GFS_RST_DIR & ~GFS_WR_DIR)))
    else $error("direction write wrong");
  AST_HOLE_READ: assert property (
    holeRead |=> ioRdData == 32'h00000000)
    else $error("hole read not zero");
  AST_FS_READ: assert property (ioRead && ioAddr[5:2] == 4'h0 |=>
    ioRdData == $past(pinFunctionSelect))
    else $error("function select read wrong");
  AST_ALT_ROUTE: assert property (
    !pinFunctionSelect[24] |=> pinOut[8] == $past(altOut[8]) &&
    pinOe[8] == $past(altOe[8]))
    else $error("alternate routing wrong on pin 24");
  AST_GPIO_DRIVE: assert property (pinFunctionSelect[24] |=> pinOe[8])
    else $error("pin 24 not driven as output");
  AST_IN_28: assert property (
    pinFunctionSelect[27] && pinDirectionSelect[28] |=> !pinOe[12])
    else $error("pin 28 driven while input");
  AST_OD_27: assert property (
    pinFunctionSelect[27] && !pinDirectionSelect[27] |=> !pinOut[11])
    else $error("pin 27 open drain drives high");
endmodule // gfs_checker
bind gfs_gpio_function_direction_select gfs_checker #(
  .FULL_VARIANT(FULL_VARIANT)
) chk (.clk_sys(clk_sys), .rst_n(rst_n), .ioAddr(ioAddr),
  .ioWrite(ioWrite), .ioRead(ioRead), .ioByteEn(ioByteEn),
  .ioWrData(ioWrData), .ioRdData(ioRdData),
  .pinFunctionSelect(pinFunctionSelect),
  .pinDirectionSelect(pinDirectionSelect), .altOut(altOut),
  .altOe(altOe), .pinOut(pinOut), .pinOe(pinOe));

// [sim/gfs_gpio_function_direction_select_tb.sv]
`timescale 1ns/1ns
module gfs_gpio_function_direction_select_tb;
  typedef struct packed {
    logic wr; logic [5:0] a; logic [31:0] d; logic [31:0] e;
  } gfs_row_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, ioWrite = 1'b0, ioRead = 1'b0;
  logic [5:0] ioAddr = 6'h00;
  logic [3:0] ioByteEn = 4'hF;
  logic [31:0] ioWrData = 32'h00000000, ioRdData, fs, redFs, rd;
  logic [31:0] flash, polInv;
  logic [12:0] altIn;
  logic [12:0] altOut = 13'h1555, altOe = 13'h0AAA, pinIn = 13'h0000;
  logic [12:0] pinOut, pinOe;
  int failCount = 0, cmpCount = 0;
  gfs_row_t rows[16] = '{
    '{1'b0, 6'h00, 32'h0, 32'h00E03060}, '{1'b0, 6'h04, 32'h0, 32'h0000FFFF},
    '{1'b0, 6'h0C, 32'h0, 32'h00200000}, '{1'b0, 6'h14, 32'h0, 32'h06630000},
    '{1'b0, 6'h18, 32'h0, 32'h0}, '{1'b0, 6'h2C, 32'h0, 32'h0},
    '{1'b1, 6'h08, 32'hFFFFFFFF, 32'h0}, '{1'b1, 6'h10, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 6'h1C, 32'hFFFFFFFF, 32'h0}, '{1'b1, 6'h24, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 6'h3C, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 6'h00, 32'hFFFFFFFF, 32'h0FE03BE3},
    '{1'b1, 6'h00, 32'h0, 32'h00E03060},
    '{1'b1, 6'h04, 32'hFFFFFFFF, 32'h1800FFFF},
    '{1'b1, 6'h04, 32'h0, 32'h0000FFFF}, '{1'b1, 6'h14, 32'h0, 32'h06630000}};
  gfs_gpio_function_direction_select uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioByteEn(ioByteEn),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .pinFunctionSelect(fs),
    .pinDirectionSelect(), .outputFlashEnable(flash),
    .inputPolarityInvert(polInv), .altOut(altOut), .altOe(altOe),
    .altIn(altIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  // Reduced variant shares the stimulus; only its select word is watched
  gfs_gpio_function_direction_select #(.FULL_VARIANT(1'b0)) uutRed (
    .clk_sys(clk_sys), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioByteEn(ioByteEn), .ioWrData(ioWrData), .ioRdData(),
    .pinFunctionSelect(redFs), .pinDirectionSelect(), .outputFlashEnable(),
    .inputPolarityInvert(), .altOut(altOut), .altOe(altOe), .altIn(),
    .pinIn(pinIn), .pinOut(), .pinOe());
  always #50 clk_sys = ~clk_sys;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task ioWr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk_sys);
    ioAddr = a;
    ioWrData = d;
    ioByteEn = be;
    ioWrite = 1'b1;
    @(negedge clk_sys);
    ioWrite = 1'b0;
  endtask
  task ioRd(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    ioAddr = a;
    ioRead = 1'b1;
    @(negedge clk_sys);
    ioRead = 1'b0;
    d = ioRdData;
  endtask
  task summarize;
    if (failCount == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    failCount++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    check(redFs, 32'h0CE030E0);
    foreach (rows[i]) begin
      if (rows[i].wr) ioWr(rows[i].a, rows[i].d, 4'hF);
      ioRd(rows[i].a, rd);
      check(rd, rows[i].e);
    end
    check({30'h0, pinOut[8], pinOe[8]}, 32'h2);
    ioWr(6'h00, 32'hFF000000, 4'h8);
    check(fs, 32'h0FE03060);
    check(redFs, 32'h0FE030E0);
    @(negedge clk_sys);
    check({31'h0, pinOe[8]}, 32'h1);
    check({28'h0, pinOut[12:11], pinOe[12:11]}, 32'h3);
    ioWr(6'h04, 32'h18000000, 4'hF);
    @(negedge clk_sys);
    check({30'h0, pinOe[12:11]}, 32'h0);
    pinIn = 13'h1001;
    repeat (5) @(negedge clk_sys);
    ioRd(6'h0C, rd);
    check(rd, 32'h10200000);
    check({19'h0, altIn}, 32'h00001FFD);
    ioWr(6'h18, 32'hFFFFFFFF, 4'hF);
    check(flash, 32'h1BE30000);
    ioWr(6'h2C, 32'hFFFFFFFF, 4'hF);
    check(polInv, 32'h18000000);
    ioWr(6'h00, 32'h00000000, 4'hF);
    check(redFs, 32'h0CE030E0);
    check(fs, 32'h00E03060);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check(fs, 32'h00E03060);
    rst_n = 1'b1;
    summarize();
  end
endmodule // gfs_gpio_function_direction_select_tb
